// File: common/hssp_consts.vh
// Purpose: Shared constants of the host serial slave port.
// Assumes: Included by the design files by bare name.
// Notes:   Command layout and strap code are fixed by this block.
`ifndef HSSP_CONSTS_VH
`define HSSP_CONSTS_VH

// ****************************************************************
// Command word layout
// ****************************************************************
`define HSSP_CMD_WRITE      31
`define HSSP_CMD_INC        30
`define HSSP_CMD_FUNC_HI    29
`define HSSP_CMD_FUNC_LO    28
`define HSSP_CMD_ADDR_HI    27
`define HSSP_CMD_ADDR_LO    11
`define HSSP_CMD_LEN_HI     10
`define HSSP_CMD_LEN_LO     0

// ****************************************************************
// Target channels
// ****************************************************************
`define HSSP_FUNC_CFG       2'h0
`define HSSP_FUNC_BACKPLANE 2'h1
`define HSSP_FUNC_CH_A      2'h2
`define HSSP_FUNC_CH_B      2'h3

// ****************************************************************
// Configuration bytes, reached by channel 0 writes at any address
// ****************************************************************
`define HSSP_CFG_WL32       0
`define HSSP_CFG_BE         1
`define HSSP_CFG_HS         4
`define HSSP_CFG_IPOL       5
`define HSSP_CFG_STEN       0
`define HSSP_CFG_DALL       2
`define HSSP_RST_WL32       1'b0
`define HSSP_RST_BE         1'b0
`define HSSP_RST_HS         1'b1
`define HSSP_RST_IPOL       1'b1
`define HSSP_RST_RDLY       8'h04
`define HSSP_RST_STEN       1'b1
`define HSSP_RST_DALL       1'b0

// ****************************************************************
// Status word layout
// ****************************************************************
`define HSSP_ST_NDA         0
`define HSSP_ST_UNF         1
`define HSSP_ST_OVF         2
`define HSSP_ST_A_INT       3
`define HSSP_ST_B_INT       4
`define HSSP_ST_A_EMPTY     5
`define HSSP_ST_B_EMPTY     6
`define HSSP_ST_A_AVAIL     8
`define HSSP_ST_A_LEN_LO    9
`define HSSP_ST_B_AVAIL     20
`define HSSP_ST_B_LEN_LO    21

// ****************************************************************
// Strap, sizes and timing
// ****************************************************************
`define HSSP_STRAP_SERIAL   3'h5
`define HSSP_MAX_WORDS      10'h200
`define HSSP_DLY_UNIT_SHIFT 3
`define HSSP_STRAP_WAIT     2'h2
`define HSSP_SCLK_MAX_HZ    48000000

`endif

// File: rtl/hssp_buf.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Read data come straight from the head register.
`timescale 1ns/1ps

module hssp_buf #(
  parameter W = 34
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);

  reg [W-1:0] head_q;
  reg [W-1:0] tail_q;
  reg         head_v_q;
  reg         tail_v_q;
  wire        push;
  wire        pop;

  assign in_ready  = ~tail_v_q;
  assign out_data  = head_q;
  assign out_valid = head_v_q;
  assign push      = in_valid & ~tail_v_q;
  assign pop       = head_v_q & out_ready;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      head_q   <= {W{1'b0}};
      tail_q   <= {W{1'b0}};
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!head_v_q) begin
            head_q   <= in_data;
            head_v_q <= 1'b1;
          end else begin
            tail_q   <= in_data;
            tail_v_q <= 1'b1;
          end
        end
        2'b01: begin
          head_q   <= tail_q;
          head_v_q <= tail_v_q;
          tail_v_q <= 1'b0;
        end
        2'b11: begin
          if (tail_v_q) begin
            head_q <= tail_q;
            tail_q <= in_data;
          end else begin
            head_q <= in_data;
          end
        end
        default: begin
          head_q <= head_q;
        end
      endcase
    end
  end

endmodule // hssp_buf

// File: rtl/hssp_top.v
// Purpose: Slave side of the generic serial host port.
// Assumes: Serial clock well below a quarter of clk; pins asynchronous.
// Notes:   Configuration lives in channel 0 bytes 0..2.
//
// Overview of operation
// - 16 or 32-bit words, selectable byte order
// - Every transaction opens with 32-bit command
// - Device captures bits on active edge
// - Read bit valid before first rising edge
// - With high-speed set, last delay edge launches first data bit
// - Split read: select released between phases
// - Optional 32-bit status after each transaction
// - Status bit 0: read data unavailable
// - Status bit 1: packet channel underflow
// - Status bit 2: write overflow
// - Bits 3-6 interrupts and receive empty
// - Bits 8-31 packet available and lengths
// - Serial clock at most 48 MHz
// - At most 2 KB per transfer
// - Little endian default, big selectable
// - Shifting edge is configurable
// - Programmable delay before read response words
// - Serial mode chosen by strap inputs
// - Response delay in 8-bit units, default 4
// - Status enable bit appends status word
// - High-speed bit: same edge, default set
// - Word-length bit, default 16-bit
`timescale 1ns/1ps
`include "hssp_consts.vh"

module hssp_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        sclk_pin,
  input  wire        cs_b_pin,
  input  wire        serial_data_in,
  input  wire [2:0]  strap_host_ifc,
  output reg         sdo_q,
  output reg         sdo_oe_q,
  output reg         irq_q,
  output reg         xfer_write_q,
  output reg  [1:0]  xfer_func_q,
  output reg  [16:0] xfer_addr_q,
  input  wire [31:0] rd_data,
  input  wire        rd_valid,
  output reg         rd_ready_q,
  output wire [31:0] wr_data,
  output wire [1:0]  wr_func,
  output wire        wr_valid,
  input  wire        wr_ready,
  input  wire        ch_a_int,
  input  wire        ch_b_int,
  input  wire        ch_a_rx_empty,
  input  wire        ch_b_rx_empty,
  input  wire        ch_a_pkt_avail,
  input  wire        ch_b_pkt_avail,
  input  wire [10:0] ch_a_pkt_len,
  input  wire [10:0] ch_b_pkt_len
);

  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_CMD   = 6'h02;
  localparam [5:0] S_DLY   = 6'h04;
  localparam [5:0] S_WDATA = 6'h08;
  localparam [5:0] S_RDATA = 6'h10;
  localparam [5:0] S_STAT  = 6'h20;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // byte order per width
  function [31:0] order;
    input [31:0] w;
    input        be;
    input        w32;
    begin
      if (be)
        order = w;
      else if (w32)
        order = {w[7:0], w[15:8], w[23:16], w[31:24]};
      else
        order = {w[23:16], w[31:24], w[7:0], w[15:8]};
    end
  endfunction

  // length 0 means a full 2 KB frame
  function [9:0] words_of;
    input [10:0] len;
    begin
      if (len == 11'h000)
        words_of = `HSSP_MAX_WORDS;
      else
        words_of = {1'b0, len[10:2]} + {9'h000, |len[1:0]};
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // link clock sampled, kept well below clk
  reg [2:0] sclk_s_q;
  reg [2:0] cs_s_q;
  reg [1:0] di_s_q;
  reg [2:0] strap_s1_q;
  reg [2:0] strap_s2_q;
  reg [1:0] strap_cnt_q;
  reg       mode_q;
  wire      rise;
  wire      fall;
  wire      cs_fall;
  wire      cs_rise;
  wire      cs_low;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_s_q   <= 3'h0;
      cs_s_q     <= 3'h7;
      di_s_q     <= 2'h0;
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      sclk_s_q   <= {sclk_s_q[1:0], sclk_pin};
      cs_s_q     <= {cs_s_q[1:0], cs_b_pin};
      di_s_q     <= {di_s_q[0], serial_data_in};
      strap_s1_q <= strap_host_ifc;
      strap_s2_q <= strap_s1_q;
    end
  end

  // sampling edge is the rising one
  assign rise    = sclk_s_q[1] & ~sclk_s_q[2];
  assign fall    = ~sclk_s_q[1] & sclk_s_q[2];
  assign cs_fall = ~cs_s_q[1] & cs_s_q[2];
  assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
  assign cs_low  = ~cs_s_q[1];

  // strap caught once after reset release
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt_q <= 2'h0;
      mode_q      <= 1'b0;
    end else if (strap_cnt_q < `HSSP_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end else if (strap_cnt_q == `HSSP_STRAP_WAIT) begin
      mode_q      <= (strap_s2_q == `HSSP_STRAP_SERIAL);
      strap_cnt_q <= 2'h3;
    end
  end

  // ****************************************************************
  // Write buffer
  // ****************************************************************
  reg         push_q;
  reg  [33:0] push_data_q;
  wire        buf_in_ready;

  hssp_buf #(.W(34)) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (push_data_q),
    .in_valid  (push_q),
    .in_ready  (buf_in_ready),
    .out_data  ({wr_func, wr_data}),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );

  // ****************************************************************
  // Transaction engine
  // ****************************************************************
  reg [5:0]  state_q;
  reg [4:0]  bit_q;
  reg [31:0] rx_q;
  reg [31:0] tx_q;
  reg [9:0]  words_q;
  reg [10:0] dly_q;
  reg        inc_q;
  reg        split_q;
  reg        nda_q;
  reg        unf_q;
  reg        ovf_q;
  reg        rise_d_q;
  reg        cs_fall_d_q;
  reg        wl32_q;
  reg        be_q;
  reg        hs_q;
  reg        ipol_q;
  reg        sten_q;
  reg        dall_q;
  reg [7:0]  rdly_q;
  reg [31:0] status;
  wire [31:0] rx_word;
  wire [31:0] rx_raw;
  wire [31:0] cfg_word;
  wire [31:0] cmd;
  wire        last_bit;
  wire        ovf_now;

  assign rx_raw   = {rx_q[30:0], di_s_q[1]};
  assign rx_word  = order(rx_raw, be_q, wl32_q);
  assign cmd      = order(rx_raw, be_q, wl32_q);
  assign last_bit = (bit_q == 5'h1F);
  // overflow of the word ending now
  assign ovf_now  = (state_q == S_WDATA) & last_bit & ~buf_in_ready
                    & (xfer_func_q != `HSSP_FUNC_CFG);
  assign cfg_word = {8'h00, 5'h00, dall_q, 1'b0, sten_q, rdly_q,
                     2'h0, ipol_q, hs_q, 2'h0, be_q, wl32_q};

  always @* begin
    status = 32'h0000_0000;
    status[`HSSP_ST_NDA] = nda_q;
    status[`HSSP_ST_UNF] = unf_q;
    status[`HSSP_ST_OVF] = ovf_q | ovf_now;
    status[`HSSP_ST_A_INT]   = ch_a_int;
    status[`HSSP_ST_B_INT]   = ch_b_int;
    status[`HSSP_ST_A_EMPTY] = ch_a_rx_empty;
    status[`HSSP_ST_B_EMPTY] = ch_b_rx_empty;
    status[`HSSP_ST_A_AVAIL] = ch_a_pkt_avail;
    status[`HSSP_ST_A_LEN_LO +: 11] = ch_a_pkt_len;
    status[`HSSP_ST_B_AVAIL] = ch_b_pkt_avail;
    status[`HSSP_ST_B_LEN_LO +: 11] = ch_b_pkt_len;
  end

  // Loads the next read word, or zeros when none is on offer
  task load_read;
    begin
      if (xfer_func_q == `HSSP_FUNC_CFG) begin
        tx_q <= order(cfg_word, be_q, wl32_q);
      end else if (rd_valid && !rd_ready_q) begin
        tx_q       <= order(rd_data, be_q, wl32_q);
        rd_ready_q <= 1'b1;
      end else begin
        tx_q  <= 32'h0000_0000;
        nda_q <= 1'b1;
        if (xfer_func_q[1])
          unf_q <= 1'b1;
      end
    end
  endtask

  // After the last data word: status word or silence
  task finish_data;
    begin
      if (sten_q) begin
        tx_q    <= order(status, be_q, wl32_q);
        state_q <= S_STAT;
      end else begin
        tx_q    <= 32'h0000_0000;
        state_q <= S_IDLE;
      end
    end
  endtask

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= S_IDLE;
      bit_q        <= 5'h00;
      rx_q         <= 32'h0000_0000;
      tx_q         <= 32'h0000_0000;
      words_q      <= 10'h000;
      dly_q        <= 11'h000;
      inc_q        <= 1'b0;
      split_q      <= 1'b0;
      nda_q        <= 1'b0;
      unf_q        <= 1'b0;
      ovf_q        <= 1'b0;
      push_q       <= 1'b0;
      push_data_q  <= 34'h0_0000_0000;
      rd_ready_q   <= 1'b0;
      xfer_write_q <= 1'b0;
      xfer_func_q  <= 2'h0;
      xfer_addr_q  <= 17'h0_0000;
      wl32_q       <= `HSSP_RST_WL32;
      be_q         <= `HSSP_RST_BE;
      hs_q         <= `HSSP_RST_HS;
      ipol_q       <= `HSSP_RST_IPOL;
      rdly_q       <= `HSSP_RST_RDLY;
      sten_q       <= `HSSP_RST_STEN;
      dall_q       <= `HSSP_RST_DALL;
    end else begin
      push_q     <= 1'b0;
      rd_ready_q <= 1'b0;
      if (!mode_q) begin
        state_q <= S_IDLE;
      end else if (cs_rise) begin
        // a read with no data yet resumes next frame
        split_q <= (state_q == S_DLY || state_q == S_RDATA)
                   && bit_q == 5'h00 && !xfer_write_q;
        state_q <= S_IDLE;
      end else if (cs_fall) begin
        bit_q <= 5'h00;
        if (split_q) begin
          // data phase of a split read
          load_read;
          state_q <= S_RDATA;
        end else begin
          state_q <= S_CMD;
        end
        split_q <= 1'b0;
      end else if (cs_low && rise) begin
        rx_q  <= rx_raw;
        bit_q <= bit_q + 5'h01;
        if (state_q == S_RDATA || state_q == S_STAT)
          tx_q <= {tx_q[30:0], 1'b0};
        case (state_q)
          S_CMD: begin
            if (last_bit) begin
              xfer_write_q <= cmd[`HSSP_CMD_WRITE];
              inc_q        <= cmd[`HSSP_CMD_INC];
              xfer_func_q  <= cmd[`HSSP_CMD_FUNC_HI:`HSSP_CMD_FUNC_LO];
              xfer_addr_q  <= cmd[`HSSP_CMD_ADDR_HI:`HSSP_CMD_ADDR_LO];
              words_q <= words_of(cmd[`HSSP_CMD_LEN_HI:`HSSP_CMD_LEN_LO]);
              nda_q <= 1'b0;
              unf_q <= 1'b0;
              ovf_q <= 1'b0;
              if (cmd[`HSSP_CMD_WRITE]) begin
                state_q <= S_WDATA;
              end else if (rdly_q != 8'h00 && (dall_q ||
                  cmd[`HSSP_CMD_FUNC_HI:`HSSP_CMD_FUNC_LO] ==
                  `HSSP_FUNC_BACKPLANE)) begin
                dly_q   <= {rdly_q, 3'h0} >> 0;
                state_q <= S_DLY;
              end else begin
                state_q <= S_RDATA;
                tx_q    <= 32'h0000_0000;
                split_q <= 1'b0;
              end
            end
          end
          S_DLY: begin
            dly_q <= dly_q - 11'h001;
            bit_q <= 5'h00;
            if (dly_q == 11'h001) begin
              // last delay edge loads first word
              load_read;
              state_q <= S_RDATA;
            end
          end
          S_WDATA: begin
            if (last_bit) begin
              if (inc_q)
                xfer_addr_q <= xfer_addr_q + 17'h0_0004;
              words_q <= words_q - 10'h001;
              if (xfer_func_q == `HSSP_FUNC_CFG) begin
                wl32_q <= rx_word[`HSSP_CFG_WL32];
                be_q   <= rx_word[`HSSP_CFG_BE];
                hs_q   <= rx_word[`HSSP_CFG_HS];
                ipol_q <= rx_word[`HSSP_CFG_IPOL];
                rdly_q <= rx_word[15:8];
                sten_q <= rx_word[16 + `HSSP_CFG_STEN];
                dall_q <= rx_word[16 + `HSSP_CFG_DALL];
              end else if (buf_in_ready) begin
                push_q      <= 1'b1;
                push_data_q <= {xfer_func_q, rx_word};
              end else begin
                ovf_q <= 1'b1;
              end
              if (words_q == 10'h001)
                finish_data;
            end
          end
          S_RDATA: begin
            if (last_bit) begin
              if (inc_q)
                xfer_addr_q <= xfer_addr_q + 17'h0_0004;
              words_q <= words_q - 10'h001;
              if (words_q == 10'h001)
                finish_data;
              else
                load_read;
            end
          end
          S_STAT: begin
            if (last_bit)
              state_q <= S_IDLE;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // normal mode launches on the falling edge
  // so the bit has half a period to settle before the host samples
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_d_q <= 1'b0;
      cs_fall_d_q <= 1'b0;
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      rise_d_q    <= rise;
      cs_fall_d_q <= cs_fall;
      // Split data phase: first bit one clk after select falls
      if ((hs_q && rise_d_q) || (!hs_q && fall) || cs_fall || cs_fall_d_q)
        sdo_q <= (state_q == S_RDATA || state_q == S_STAT) & tx_q[31];
      // data out driven only while selected
      sdo_oe_q <= mode_q & cs_low;
      irq_q <= mode_q ? ((ch_a_int | ch_b_int) ~^ ipol_q) : 1'b0;
    end
  end

endmodule // hssp_top

// File: tb/hssp_checker.sv
// Purpose: Port assertions for the host serial slave port.
// Assumes: Interrupt polarity stays at its reset value.
// Notes:   Bound into hssp_top after the module.
`timescale 1ns/1ps

module hssp_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        cs_b_pin,
  input wire logic [2:0]  strap_host_ifc,
  input wire logic        sdo_oe_q,
  input wire logic        irq_q,
  input wire logic        ch_a_int,
  input wire logic        ch_b_int,
  input wire logic        rd_valid,
  input wire logic        rd_ready_q,
  input wire logic [31:0] wr_data,
  input wire logic [1:0]  wr_func,
  input wire logic        wr_valid,
  input wire logic        wr_ready
);
  logic [3:0] age_q;

  // Mode capture settles a few cycles after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence live_s;
    age_q == 4'hF && strap_host_ifc == 3'h5;
  endsequence
  sequence ints_steady_s;
    $stable(ch_a_int | ch_b_int) [*3];
  endsequence
  sequence selected_s;
    (!cs_b_pin && strap_host_ifc == 3'h5 && age_q == 4'hF) [*5];
  endsequence

  irq_map_a: assert property (
    live_s ##0 ints_steady_s |-> irq_q == (ch_a_int | ch_b_int))
    else $error("irq does not follow channel interrupts");
  oe_on_a: assert property (
    selected_s |-> sdo_oe_q) else $error("data out idle while selected");
  oe_off_a: assert property (
    cs_b_pin [*5] |-> !sdo_oe_q) else $error("data out driven while idle");
  no_mode_a: assert property (
    (strap_host_ifc != 3'h5) [*6] |-> !sdo_oe_q && !irq_q)
    else $error("outputs active outside serial mode");
  rd_pulse_a: assert property (
    rd_ready_q |=> !rd_ready_q) else $error("read take held too long");
  rd_cause_a: assert property (
    rd_ready_q |-> $past(rd_valid)) else $error("word taken while not valid");
  wr_hold_a: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_func))
    else $error("stalled write word changed");
  wr_chan_a: assert property (
    wr_valid |-> wr_func != 2'h0) else $error("config word sent to sink");
endmodule // hssp_checker

bind hssp_top hssp_checker chk_i (.*);

// File: tb/hssp_host.sv
// Purpose: Behavioural host mastering the serial link.
// Assumes: Bench calls the tasks; clk only paces the edges.
// Notes:   Link clock stands still low outside frames.
`timescale 1ns/1ps

module hssp_host (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      cs_b,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b1;
  end

  // select drops to open each phase
  task sel;
    @(negedge clk);
    cs_b = 1'b0;
  endtask

  // release; released line never shows the last bit
  task desel;
    repeat (4) @(negedge clk);
    cs_b = 1'b1;
    mosi = ~mosi;
  endtask

  // 32 bits MSB first, 800 ns per bit
  task xfer(input logic [31:0] w, output logic [31:0] r);
    for (int k = 31; k >= 0; k--) begin
      mosi = w[k];
      repeat (4) @(negedge clk);
      r[k] = sdo;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
endmodule // hssp_host

// File: tb/hssp_top_tb.sv
// Purpose: Self-checking bench for the host serial slave port.
// Assumes: Host model runs the link at 800 ns per bit.
// Notes:   Expected words come from a queue model of the sink.
`timescale 1ns/1ps

module hssp_top_tb;
  logic        clk, rst_b, rd_valid, wr_ready, be, w32;
  logic [2:0]  strap;
  logic [27:0] chin;
  logic [31:0] rd_data, rnd, r;
  logic [31:0] txw [0:2];
  logic [31:0] rxw [0:2];
  logic [31:0] expq [$];
  logic [31:0] sinkq [$];
  wire         ch_a_int, ch_b_int, ch_a_rx_empty, ch_b_rx_empty;
  wire         ch_a_pkt_avail, ch_b_pkt_avail, rd_ready_q, wr_valid;
  wire         sclk, cs_b, mosi, sdo_q, sdo_oe_q, irq_q;
  wire  [10:0] ch_a_pkt_len, ch_b_pkt_len;
  wire         xw;
  wire  [1:0]  wr_func, xf;
  wire  [16:0] xa;
  wire  [31:0] wr_data;
  integer      seed, miscompares, compares;

  assign {ch_a_int, ch_b_int, ch_a_rx_empty, ch_b_rx_empty, ch_a_pkt_avail,
          ch_b_pkt_avail, ch_a_pkt_len, ch_b_pkt_len} = chin;

  hssp_host host (.clk(clk), .sdo(sdo_q), .sclk(sclk), .cs_b(cs_b),
                  .mosi(mosi));
  hssp_top uut (
    .clk(clk), .rst_b(rst_b), .sclk_pin(sclk), .cs_b_pin(cs_b),
    .serial_data_in(mosi), .strap_host_ifc(strap), .sdo_q(sdo_q),
    .sdo_oe_q(sdo_oe_q), .irq_q(irq_q), .xfer_write_q(xw),
    .xfer_func_q(xf), .xfer_addr_q(xa), .rd_data(rd_data),
    .rd_valid(rd_valid),
    .rd_ready_q(rd_ready_q), .wr_data(wr_data), .wr_func(wr_func),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .ch_a_int(ch_a_int),
    .ch_b_int(ch_b_int), .ch_a_rx_empty(ch_a_rx_empty),
    .ch_b_rx_empty(ch_b_rx_empty), .ch_a_pkt_avail(ch_a_pkt_avail),
    .ch_b_pkt_avail(ch_b_pkt_avail), .ch_a_pkt_len(ch_a_pkt_len),
    .ch_b_pkt_len(ch_b_pkt_len)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      sinkq.push_back(wr_data);
    end
  end

  function automatic logic [31:0] ord(input logic [31:0] w);
    if (be) return w;
    if (w32) return {w[7:0], w[15:8], w[23:16], w[31:24]};
    return {w[23:16], w[31:24], w[7:0], w[15:8]};
  endfunction

  function automatic logic [31:0] stx(input logic [2:0] err);
    return {ch_b_pkt_len, ch_b_pkt_avail, ch_a_pkt_len, ch_a_pkt_avail,
            1'b0, ch_b_rx_empty, ch_a_rx_empty, ch_b_int, ch_a_int, err};
  endfunction

  function automatic logic [31:0] cmd(input logic wr, input logic [1:0] f,
                                      input logic [10:0] n);
    return {wr, 1'b1, f, (f == 2'h0) ? 17'h0 : 17'h10, n};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task reset(input logic [2:0] s);
    @(negedge clk);
    rst_b = 1'b0;
    strap = s;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  task shuffle;
    @(negedge clk);
    rnd = $random(seed);
    chin = rnd[27:0];
    repeat (4) @(negedge clk);
    chk({31'h0, irq_q}, {31'h0, ch_a_int | ch_b_int});
  endtask

  task frame(input logic [31:0] c, input integer nd, input integer nz,
             input logic split, input logic [2:0] err);
    host.sel();
    host.xfer(ord(c), r);
    if (split) begin
      host.desel();
      repeat (20) @(negedge clk);
      host.sel();
    end
    for (int k = 0; k < nz; k++) begin
      host.xfer(32'h0, r);
      chk(r, 32'h0);
    end
    for (int k = 0; k < nd; k++) begin
      host.xfer(ord(txw[k]), r);
      rxw[k] = ord(r);
    end
    host.xfer(32'h0, r);
    chk(ord(r), stx(err));
    host.desel();
  endtask

  // host writes a configuration word through channel 0
  task setup(input logic [31:0] v);
    host.sel();
    host.xfer(ord(cmd(1'b1, 2'h0, 11'h4)), r);
    host.xfer(ord(v), r);
    host.xfer(32'h0, r);
    host.desel();
  endtask

  task drain;
    wr_ready = 1'b1;
    repeat (10) @(negedge clk);
    chk(32'(sinkq.size()), 32'(expq.size()));
    while (expq.size() > 0 && sinkq.size() > 0) begin
      chk(sinkq.pop_front(), expq.pop_front());
    end
  endtask

  initial begin
    seed = 11057;
    compares = 0;
    miscompares = 0;
    {rst_b, rd_valid, wr_ready, be, w32, strap} = 8'h22;
    chin = 28'h8000000;
    rd_data = 32'h0;
    reset(3'h2);
    host.sel();
    repeat (10) @(negedge clk);
    chk({30'h0, sdo_oe_q, irq_q}, 32'h0);
    host.desel();
    reset(3'h5);
    chk({31'h0, irq_q}, 32'h1);
    shuffle();
    txw[0] = $random(seed);
    expq.push_back(txw[0]);
    frame(cmd(1'b1, 2'h1, 11'h4), 1, 0, 1'b0, 3'h0);
    chk({12'h0, xw, xf, xa}, {12'h0, 1'b1, 2'h1, 17'h14});
    drain();
    wr_ready = 1'b0;
    shuffle();
    for (int k = 0; k < 3; k++) txw[k] = $random(seed);
    expq.push_back(txw[0]);
    expq.push_back(txw[1]);
    frame(cmd(1'b1, 2'h2, 11'hC), 3, 0, 1'b0, 3'h4);
    drain();
    shuffle();
    rd_data = $random(seed);
    rd_valid = 1'b1;
    frame(cmd(1'b0, 2'h1, 11'h4), 1, 1, 1'b0, 3'h0);
    chk(rxw[0], rd_data);
    rd_valid = 1'b0;
    frame(cmd(1'b0, 2'h1, 11'h4), 1, 1, 1'b0, 3'h1);
    frame(cmd(1'b0, 2'h2, 11'h4), 1, 0, 1'b1, 3'h3);
    setup(32'h0001_0423);
    {be, w32} = 2'h3;
    shuffle();
    rd_data = $random(seed);
    rd_valid = 1'b1;
    frame(cmd(1'b0, 2'h3, 11'h4), 1, 0, 1'b1, 3'h0);
    chk(rxw[0], rd_data);
    shuffle();
    txw[0] = $random(seed);
    expq.push_back(txw[0]);
    frame(cmd(1'b1, 2'h3, 11'h4), 1, 0, 1'b0, 3'h0);
    drain();
    setup(32'h0004_0433);
    rd_data = $random(seed);
    host.sel();
    host.xfer(cmd(1'b0, 2'h2, 11'h4), r);
    host.xfer(32'h0, r);
    chk(r, 32'h0);
    host.xfer(32'h0, r);
    chk(r, rd_data);
    host.xfer(32'h0, r);
    chk(r, 32'h0);
    host.desel();
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run();
  end
endmodule // hssp_top_tb
